// *** core/afe_sync_pkg.sv ***
// Constants for the pattern, sync and power-down control block
`default_nettype none
package afe_sync_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CUSTOM   = 8'h04;
    localparam logic [7:0] OFS_AMP_CH   = 8'h08;
    localparam logic [7:0] OFS_CONV_ANA = 8'h0C;
    localparam logic [7:0] OFS_CONV_DIG = 8'h10;
    localparam logic [7:0] OFS_LINE_PD  = 8'h14;
    localparam logic [7:0] OFS_PAT_LO   = 8'h18;
    localparam logic [7:0] OFS_PAT_HI   = 8'h1C;
    localparam logic [7:0] OFS_STATUS   = 8'h20;
    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int CTRL_SW_SYNC   = 0;
    localparam int CTRL_TRIG_MASK = 1;
    localparam int CTRL_PER_LINE  = 2;
    localparam int CTRL_GPAT_LSB  = 4;
    localparam int CTRL_AMP_GBL   = 8;
    localparam int CTRL_AMP_FAST  = 9;
    localparam int CTRL_LNA_ONLY  = 10;
    localparam int CTRL_FILT_ONLY = 11;
    localparam int CTRL_CONV_GBL  = 12;
    localparam int CTRL_SER_DIS   = 13;
    localparam int CTRL_W         = 14;
    localparam int PAT_FIELD_W    = 3;
    localparam int LINES_PER_REG  = 8;
    localparam int CUSTOM_W       = 16;
    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [CTRL_W-1:0]   CTRL_RESET   = 14'h0000;
    localparam logic [CUSTOM_W-1:0] CUSTOM_RESET = 16'h0000;
    localparam logic [15:0]         MASK_RESET   = 16'h0000;
    localparam logic [23:0]         PAT_RESET    = 24'h00_0000;
    localparam logic [2:0]          INVALID_CLOCKS = 3'h6;
    // ****************************************************************
    // Pattern codes
    // ****************************************************************
    typedef enum logic [2:0] {
        PAT_NORMAL = 3'h0,
        PAT_ZEROS  = 3'h1,
        PAT_ONES   = 3'h2,
        PAT_DESKEW = 3'h3,
        PAT_SYNC   = 3'h4,
        PAT_CUSTOM = 3'h5,
        PAT_RAMP   = 3'h6,
        PAT_TOGGLE = 3'h7
    } pattern_type;
endpackage
`default_nettype wire

// *** core/pin_synchroniser.sv ***
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_synchroniser #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

    initial begin
        if (WIDTH < 1) $error("pin_synchroniser: WIDTH below 1");
    end

    // ****************************************************************
    // Stages
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1    <= '0;
            stage2    <= '0;
            stage3    <= '0;
            pin_level <= '0;
        end else begin
            stage1    <= pin_in;
            stage2    <= stage1;
            stage3    <= stage2;
            pin_level <= (agree & stage3) | (~agree & pin_level);
        end
    end
endmodule
`default_nettype wire

// *** core/afe_pattern_sync_power_down.sv ***
// Test pattern substitution, pattern sync and power-down decoding
//
// Added by the designer: register access over APB and the address map.
`default_nettype none
// Behaviour
// RULE1: Trigger pin or bit set-clear resyncs patterns
// RULE2: Output invalid four to six clocks after trigger
// RULE3: Mask bit makes trigger pin ignored
// RULE4: Amp band-gap, attenuator, serial stay powered
// RULE5: Global/fast controls power down amp blocks
// RULE6: Channel, amplifier-only, filter-only amp power-downs
// RULE7: Several controls give union of power-downs
// RULE8: Converter band-gap and serial stay powered
// RULE9: Global/fast controls power down converter blocks
// RULE10: Serial disable and per-line serializer power-down
// RULE11: Per-channel analog and digital power-down
// RULE12: Selected pattern replaces converter data
// RULE13: Global field or per-line fields choose pattern
// RULE14: Zeros pattern is all bits zero
// RULE15: Ones pattern is all bits one
// RULE16: Deskew pattern alternates starting with zero
// RULE17: Sync pattern upper half ones
// RULE18: Custom pattern uses word's top bits
// RULE19: Codes defined, one keeps normal data
// RULE20: Ramp steps 2^(S-N) and wraps
module afe_pattern_sync_power_down
    import afe_sync_pkg::*;
#(
    parameter int LINES = 16,
    parameter int SER_W = 14,
    parameter int RES_W = 14
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output logic                        pready,
    output var  logic                   pslverr,
    input  wire logic                   conv_clk_pin,
    input  wire logic                   sync_trigger_pin,
    input  wire logic                   global_powerdown_pin,
    input  wire logic                   fast_powerdown_pin,
    input  wire logic [LINES*SER_W-1:0] adc_data,
    output var  logic [LINES*SER_W-1:0] serial_data_line,
    output logic                        sample_invalid,
    output var  logic [LINES-1:0]       amp_lna_pd,
    output var  logic [LINES-1:0]       amp_filter_pd,
    output var  logic [LINES-1:0]       amp_mixer_switch_pd,
    output var  logic                   amp_gain_engine_pd,
    output var  logic                   amp_reference_pd,
    output var  logic                   amp_phase_gen_pd,
    output var  logic [LINES-1:0]       conv_analog_pd,
    output var  logic [LINES-1:0]       conv_digital_pd,
    output var  logic [LINES-1:0]       data_serializer_pd,
    output var  logic                   frame_clock_ser_pd,
    output var  logic                   conv_reference_pd,
    output var  logic                   pll_pd,
    output logic                        always_on_pd
);
    import afe_sync_pkg::*;
    initial begin
        if (LINES < 1 || LINES > 16) $error("LINES must be 1 to 16");
        if (SER_W < RES_W || SER_W > CUSTOM_W) $error("SER_W out of range");
        if (RES_W < 2) $error("RES_W below 2");
    end
    // ****************************************************************
    // Registers and synchronised pins
    // ****************************************************************
    logic [CTRL_W-1:0]   ctrl;
    logic [CUSTOM_W-1:0] custom_word;
    logic [15:0]         amp_ch_bits;
    logic [15:0]         ana_bits;
    logic [15:0]         dig_bits;
    logic [15:0]         line_pd_bits;
    logic [47:0]         line_pat;
    logic [3:0]          pins;
    logic                conv_prev;
    logic                trig_prev;
    logic                sw_sync_prev;
    logic [RES_W-1:0]    ramp;
    logic                toggle;
    logic [2:0]          invalid_cnt;
    pin_synchroniser #(.WIDTH(4)) u_pins (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    ({fast_powerdown_pin, global_powerdown_pin, sync_trigger_pin, conv_clk_pin}),
        .pin_level (pins)
    );
    wire conv_level = pins[0];
    wire trig_level = pins[1];
    wire gbl_pin    = pins[2];
    wire fast_pin   = pins[3];
    wire conv_tick  = conv_level & ~conv_prev;
    wire trig_edge  = trig_level & ~trig_prev;
    wire sw_sync_fall = sw_sync_prev & ~ctrl[CTRL_SW_SYNC];
    // RULE3: mask blocks pin
    wire trig_accept = trig_edge & ~ctrl[CTRL_TRIG_MASK];
    // RULE1: pin or bit resync
    wire phase_reset = trig_accept | sw_sync_fall;
    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire setup_phase = psel & ~penable;
    wire wr_access   = psel & penable & pwrite;
    wire hit_ctrl    = paddr == OFS_CTRL;
    wire hit_custom  = paddr == OFS_CUSTOM;
    wire hit_amp     = paddr == OFS_AMP_CH;
    wire hit_ana     = paddr == OFS_CONV_ANA;
    wire hit_dig     = paddr == OFS_CONV_DIG;
    wire hit_linepd  = paddr == OFS_LINE_PD;
    wire hit_pat_lo  = paddr == OFS_PAT_LO;
    wire hit_pat_hi  = paddr == OFS_PAT_HI;
    wire hit_status  = paddr == OFS_STATUS;
    wire mapped      = hit_ctrl | hit_custom | hit_amp | hit_ana | hit_dig
                     | hit_linepd | hit_pat_lo | hit_pat_hi | hit_status;
    wire [31:0] status_word = {28'h000_0000, fast_pin, gbl_pin, trig_level, sample_invalid};
    wire [31:0] read_mux =
          hit_ctrl   ? {18'h0_0000, ctrl}
        : hit_custom ? {16'h0000, custom_word}
        : hit_amp    ? {16'h0000, amp_ch_bits}
        : hit_ana    ? {16'h0000, ana_bits}
        : hit_dig    ? {16'h0000, dig_bits}
        : hit_linepd ? {16'h0000, line_pd_bits}
        : hit_pat_lo ? {8'h00, line_pat[23:0]}
        : hit_pat_hi ? {8'h00, line_pat[47:24]}
        : hit_status ? status_word
        : 32'h0000_0000;
    assign pready = 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= read_mux;
            pslverr <= ~mapped;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl         <= CTRL_RESET;
            custom_word  <= CUSTOM_RESET;
            amp_ch_bits  <= MASK_RESET;
            ana_bits     <= MASK_RESET;
            dig_bits     <= MASK_RESET;
            line_pd_bits <= MASK_RESET;
            line_pat     <= {PAT_RESET, PAT_RESET};
        end else if (wr_access) begin
            if (hit_ctrl) ctrl <= pwdata[CTRL_W-1:0];
            if (hit_custom) custom_word <= pwdata[CUSTOM_W-1:0];
            if (hit_amp) amp_ch_bits <= pwdata[15:0];
            if (hit_ana) ana_bits <= pwdata[15:0];
            if (hit_dig) dig_bits <= pwdata[15:0];
            if (hit_linepd) line_pd_bits <= pwdata[15:0];
            if (hit_pat_lo) line_pat[23:0] <= pwdata[23:0];
            if (hit_pat_hi) line_pat[47:24] <= pwdata[23:0];
        end
    end
    // ****************************************************************
    // Pattern generators and sync
    // ****************************************************************
    localparam logic [RES_W-1:0] NEG_FS = RES_W'(1) << (RES_W - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_prev    <= 1'b0;
            trig_prev    <= 1'b0;
            sw_sync_prev <= 1'b0;
        end else begin
            conv_prev    <= conv_level;
            trig_prev    <= trig_level;
            sw_sync_prev <= ctrl[CTRL_SW_SYNC];
        end
    end
    // RULE1: restart ramp and toggle
    // RULE20: ramp steps and wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp   <= NEG_FS;
            toggle <= 1'b0;
        end else if (phase_reset) begin
            ramp   <= NEG_FS;
            toggle <= 1'b0;
        end else if (conv_tick) begin
            ramp   <= ramp + RES_W'(1);
            toggle <= ~toggle;
        end
    end
    // RULE2: flag corrupted samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            invalid_cnt <= 3'h0;
        end else if (trig_accept) begin
            invalid_cnt <= INVALID_CLOCKS;
        end else if (conv_tick && invalid_cnt != 3'h0) begin
            invalid_cnt <= invalid_cnt - 3'h1;
        end
    end
    assign sample_invalid = invalid_cnt != 3'h0;
    // RULE14: zeros
    // RULE15: ones
    // RULE16: deskew
    // RULE17: sync
    // RULE18: custom top bits
    // RULE19: normal code passes data
    function automatic logic [SER_W-1:0] pick(input logic [2:0] code,
                                              input logic [SER_W-1:0] adc,
                                              input logic [CUSTOM_W-1:0] cw,
                                              input logic [RES_W-1:0] rp, input logic tg);
        logic [SER_W-1:0] w;
        w = adc;
        unique case (pattern_type'(code))
            PAT_NORMAL: w = adc;
            PAT_ZEROS:  w = '0;
            PAT_ONES:   w = '1;
            PAT_DESKEW: for (int b = 0; b < SER_W; b++) w[b] = ~b[0];
            PAT_SYNC:   for (int b = 0; b < SER_W; b++) w[b] = b >= SER_W / 2;
            PAT_CUSTOM: w = cw[CUSTOM_W-1 -: SER_W];
            PAT_RAMP:   w = {rp, {(SER_W - RES_W){1'b0}}};
            PAT_TOGGLE: w = {SER_W{tg}};
        endcase
        return w;
    endfunction
    // ****************************************************************
    // Per-line substitution
    // ****************************************************************
    logic [LINES*SER_W-1:0] next_serial_data_line;
    for (genvar l = 0; l < LINES; l++) begin : g_line
        // RULE13: global or per-line field
        wire [2:0] code = ctrl[CTRL_PER_LINE] ? line_pat[l*PAT_FIELD_W +: PAT_FIELD_W]
                                              : ctrl[CTRL_GPAT_LSB +: PAT_FIELD_W];
        // RULE12: pattern replaces data
        assign next_serial_data_line[l*SER_W +: SER_W] =
            pick(code, adc_data[l*SER_W +: SER_W], custom_word, ramp, toggle);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_data_line <= '0;
        end else if (conv_tick) begin
            serial_data_line <= next_serial_data_line;
        end
    end
    // ****************************************************************
    // Power-down decode
    // ****************************************************************
    wire amp_gbl  = gbl_pin | ctrl[CTRL_AMP_GBL];
    wire amp_fast = fast_pin | ctrl[CTRL_AMP_FAST];
    wire conv_gbl = gbl_pin | ctrl[CTRL_CONV_GBL];
    wire conv_any = conv_gbl | fast_pin;
    wire [LINES-1:0] amp_ch = amp_ch_bits[LINES-1:0];
    // RULE4: amp keep-alive blocks
    // RULE8: converter keep-alive blocks
    assign always_on_pd = 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_lna_pd          <= '0;
            amp_filter_pd       <= '0;
            amp_mixer_switch_pd <= '0;
            amp_gain_engine_pd  <= 1'b0;
            amp_reference_pd    <= 1'b0;
            amp_phase_gen_pd    <= 1'b0;
            conv_analog_pd      <= '0;
            conv_digital_pd     <= '0;
            data_serializer_pd  <= '0;
            frame_clock_ser_pd  <= 1'b0;
            conv_reference_pd   <= 1'b0;
            pll_pd              <= 1'b0;
        end else begin
            // RULE5: global and fast amp
            // RULE6: channel and block-only bits
            // RULE7: union of controls
            amp_lna_pd <= {LINES{amp_gbl | amp_fast | ctrl[CTRL_LNA_ONLY]}} | amp_ch;
            amp_filter_pd <= {LINES{amp_gbl | amp_fast | ctrl[CTRL_FILT_ONLY]}} | amp_ch;
            amp_mixer_switch_pd <= {LINES{amp_gbl | amp_fast}} | amp_ch;
            amp_gain_engine_pd  <= amp_gbl;
            amp_reference_pd    <= amp_gbl;
            amp_phase_gen_pd    <= amp_gbl | amp_fast;
            // RULE9: global and fast converter
            // RULE11: per-channel analog, digital
            conv_analog_pd  <= {LINES{conv_any}} | ana_bits[LINES-1:0];
            conv_digital_pd <= {LINES{conv_any}} | dig_bits[LINES-1:0];
            // RULE10: serializer disable bits
            data_serializer_pd <= {LINES{conv_any | ctrl[CTRL_SER_DIS]}} | line_pd_bits[LINES-1:0];
            frame_clock_ser_pd <= conv_gbl | ctrl[CTRL_SER_DIS];
            conv_reference_pd  <= conv_gbl;
            pll_pd             <= conv_gbl;
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_resync;
        phase_reset |=> ramp == NEG_FS && !toggle;
    endproperty
    a_resync: assert property (p_resync) else $error("pattern not resynced"); // RULE1
    property p_invalid;
        trig_accept |=> sample_invalid && invalid_cnt == INVALID_CLOCKS;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid flag missing"); // RULE2
    property p_mask;
        trig_edge && ctrl[CTRL_TRIG_MASK] && !sw_sync_fall |=> $stable(ramp) || $past(conv_tick);
    endproperty
    a_mask: assert property (p_mask) else $error("masked trigger acted"); // RULE3
    property p_amp_gbl;
        gbl_pin |=> amp_gain_engine_pd && amp_reference_pd && (&amp_mixer_switch_pd);
    endproperty
    a_amp_gbl: assert property (p_amp_gbl) else $error("amp global pd wrong"); // RULE5
    property p_amp_fast;
        fast_pin && !ctrl[CTRL_AMP_GBL] && !gbl_pin |=>
            !amp_gain_engine_pd && amp_phase_gen_pd && (&amp_lna_pd);
    endproperty
    a_amp_fast: assert property (p_amp_fast) else $error("amp fast pd wrong"); // RULE5
    property p_amp_ch;
        ##1 (amp_lna_pd & $past(amp_ch)) == $past(amp_ch);
    endproperty
    a_amp_ch: assert property (p_amp_ch) else $error("channel pd missing"); // RULE6
    property p_conv_fast;
        fast_pin && !conv_gbl && !ctrl[CTRL_SER_DIS] |=>
            !pll_pd && !frame_clock_ser_pd && (&conv_analog_pd);
    endproperty
    a_conv_fast: assert property (p_conv_fast) else $error("conv fast pd wrong"); // RULE9
    property p_ser_dis;
        ctrl[CTRL_SER_DIS] |=> frame_clock_ser_pd && (&data_serializer_pd);
    endproperty
    a_ser_dis: assert property (p_ser_dis) else $error("serial disable wrong"); // RULE10
    property p_ones;
        conv_tick && !ctrl[CTRL_PER_LINE] && ctrl[CTRL_GPAT_LSB +: 3] == PAT_ONES
            |=> serial_data_line[SER_W-1:0] == {SER_W{1'b1}};
    endproperty
    a_ones: assert property (p_ones) else $error("ones pattern wrong"); // RULE15
    property p_zeros;
        conv_tick && !ctrl[CTRL_PER_LINE] && ctrl[CTRL_GPAT_LSB +: 3] == PAT_ZEROS
            |=> serial_data_line[SER_W-1:0] == '0;
    endproperty
    a_zeros: assert property (p_zeros) else $error("zeros pattern wrong"); // RULE14
endmodule
`default_nettype wire

// *** test/fpga_receiver.sv ***
// Far-end receiver model: conversion clock source and word capture
`default_nettype none
module fpga_receiver (
    input  wire logic        pclk,
    input  wire logic        sample_invalid,
    input  wire logic [13:0] word,
    output var  logic        conv_clk,
    output var  logic [13:0] prev_word,
    output var  logic [13:0] last_word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [13:0] seen;
    // ****
    // Free-running conversion clock, 125 ns
    // ****
    initial begin
        conv_clk = 1'b0;
        #3.0;
        forever #62.5 conv_clk = ~conv_clk;
    end
    // ****
    // Word capture
    // ****
    // drop corrupt samples
    always_ff @(posedge pclk) begin
        seen <= word;
        if (word !== seen && sample_invalid === 1'b0) begin
            prev_word <= last_word;
            last_word <= word;
        end
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for pattern, sync and power-down control
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import afe_sync_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, trig, gpin, fpin, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic pready, pslverr, conv_clk, sample_invalid, always_on_pd;
    logic [223:0] adc_data, serial_data_line;
    logic [15:0] amp_lna_pd, amp_filter_pd, amp_mixer_switch_pd;
    logic [15:0] conv_analog_pd, conv_digital_pd, data_serializer_pd;
    logic amp_gain_engine_pd, amp_reference_pd, amp_phase_gen_pd;
    logic frame_clock_ser_pd, conv_reference_pd, pll_pd;
    logic [13:0] prev_word, last_word;
    int num_errors, n_tests, k, cnt;
    wire logic [11:0] pd_and = {&amp_lna_pd, &amp_filter_pd, &amp_mixer_switch_pd,
        amp_gain_engine_pd, amp_reference_pd, amp_phase_gen_pd, &conv_analog_pd,
        &conv_digital_pd, &data_serializer_pd, frame_clock_ser_pd, conv_reference_pd, pll_pd};
    wire logic [11:0] pd_or = {|amp_lna_pd, |amp_filter_pd, |amp_mixer_switch_pd,
        amp_gain_engine_pd, amp_reference_pd, amp_phase_gen_pd, |conv_analog_pd,
        |conv_digital_pd, |data_serializer_pd, frame_clock_ser_pd, conv_reference_pd, pll_pd};
    localparam logic [16:0] PAT_ROWS [6] = '{{PAT_NORMAL, 14'h1234}, {PAT_ZEROS, 14'h0000},
        {PAT_ONES, 14'h3FFF}, {PAT_DESKEW, 14'h1555}, {PAT_SYNC, 14'h3F80},
        {PAT_CUSTOM, 14'h32D7}};
    // Rows: control word, global and fast pins, expected power-down set
    localparam logic [27:0] PWR_ROWS [10] = '{{14'h0000, 2'h0, 12'h000},
        {14'h0100, 2'h0, 12'hFC0}, {14'h0200, 2'h0, 12'hE40}, {14'h0400, 2'h0, 12'h800},
        {14'h0800, 2'h0, 12'h400}, {14'h1000, 2'h0, 12'h03F}, {14'h2000, 2'h0, 12'h00C},
        {14'h2C00, 2'h0, 12'hC0C}, {14'h0000, 2'h2, 12'hFFF}, {14'h0000, 2'h1, 12'hE78}};
    afe_pattern_sync_power_down uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_clk_pin(conv_clk),
        .sync_trigger_pin(trig), .global_powerdown_pin(gpin), .fast_powerdown_pin(fpin),
        .adc_data(adc_data), .serial_data_line(serial_data_line),
        .sample_invalid(sample_invalid), .amp_lna_pd(amp_lna_pd),
        .amp_filter_pd(amp_filter_pd), .amp_mixer_switch_pd(amp_mixer_switch_pd),
        .amp_gain_engine_pd(amp_gain_engine_pd), .amp_reference_pd(amp_reference_pd),
        .amp_phase_gen_pd(amp_phase_gen_pd), .conv_analog_pd(conv_analog_pd),
        .conv_digital_pd(conv_digital_pd), .data_serializer_pd(data_serializer_pd),
        .frame_clock_ser_pd(frame_clock_ser_pd), .conv_reference_pd(conv_reference_pd),
        .pll_pd(pll_pd), .always_on_pd(always_on_pd));
    fpga_receiver rx (.pclk(pclk), .sample_invalid(sample_invalid),
        .word(serial_data_line[13:0]), .conv_clk(conv_clk), .prev_word(prev_word),
        .last_word(last_word));
    // ****
    // Clock and shared tasks
    // ****
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            num_errors++;
            final_report();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_inv(input logic lvl, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge pclk);
            if (sample_invalid === lvl) break;
        end
        if (n == lim) begin
            num_errors++;
            final_report();
        end
    endtask
    task automatic pulse();
        trig <= 1'b1;
        cyc(5);
        trig <= 1'b0;
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        {presetn, psel, penable, pwrite, trig, gpin, fpin} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        adc_data = {16{14'h1234}};
        num_errors = 0;
        n_tests = 0;
        cyc(3);
        presetn <= 1'b1;
        chk("pd after reset", 32'(pd_or), 32'h0000_0000);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrl reset", rd_data, 32'(CTRL_RESET));
        apb(1'b0, OFS_AMP_CH, 32'h0000_0000);
        chk("mask reset", rd_data, 32'(MASK_RESET));
        apb(1'b0, OFS_PAT_LO, 32'h0000_0000);
        chk("pattern reset", rd_data, 32'(PAT_RESET));
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk("unmapped data", rd_data, 32'h0000_0000);
        chk("unmapped error", 32'(rd_err), 32'h0000_0001);
        apb(1'b1, OFS_CUSTOM, 32'h0000_CB5E);
        apb(1'b0, OFS_CUSTOM, 32'h0000_0000);
        chk("custom readback", rd_data, 32'h0000_CB5E);
        for (k = 0; k < 6; k++) begin
            apb(1'b1, OFS_CTRL, 32'(PAT_ROWS[k][16:14]) << CTRL_GPAT_LSB);
            cyc(30);
            chk("line0 word", 32'(serial_data_line[13:0]), 32'(PAT_ROWS[k][13:0]));
            chk("line15 word", 32'(serial_data_line[223:210]), 32'(PAT_ROWS[k][13:0]));
        end
        for (k = 0; k < 10; k++) begin
            apb(1'b1, OFS_CTRL, 32'(PWR_ROWS[k][27:14]));
            gpin <= PWR_ROWS[k][13];
            fpin <= PWR_ROWS[k][12];
            cyc(8);
            chk("pd all", 32'(pd_and), 32'(PWR_ROWS[k][11:0]));
            chk("pd any", 32'(pd_or), 32'(PWR_ROWS[k][11:0]));
            chk("always on", 32'(always_on_pd), 32'h0000_0000);
        end
        gpin <= 1'b0;
        fpin <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        apb(1'b1, OFS_AMP_CH, 32'h0000_0005);
        apb(1'b1, OFS_CONV_ANA, 32'h0000_0100);
        apb(1'b1, OFS_CONV_DIG, 32'h0000_8000);
        apb(1'b1, OFS_LINE_PD, 32'h0000_0002);
        cyc(3);
        chk("amp chan", 32'({amp_lna_pd, amp_mixer_switch_pd}), 32'h0005_0005);
        chk("amp chan filter", 32'(amp_filter_pd), 32'h0000_0005);
        chk("conv chan", 32'({conv_analog_pd, conv_digital_pd}), 32'h0100_8000);
        chk("line pd", 32'({frame_clock_ser_pd, data_serializer_pd}), 32'h0000_0002);
        apb(1'b1, OFS_CTRL, 32'h0000_0004 | (32'(PAT_ONES) << CTRL_GPAT_LSB));
        apb(1'b1, OFS_PAT_LO, 32'h0000_0011);
        cyc(30);
        chk("per line", 32'(serial_data_line[41:0]), 32'({14'h1234, 14'h3FFF, 14'h0000}));
        chk("per line 2", 32'(serial_data_line[41:28]), 32'h0000_1234);
        apb(1'b1, OFS_CTRL, 32'(PAT_TOGGLE) << CTRL_GPAT_LSB);
        cyc(40);
        chk("toggle", 32'(last_word ^ prev_word), 32'h0000_3FFF);
        apb(1'b1, OFS_CTRL, 32'(PAT_RAMP) << CTRL_GPAT_LSB);
        cyc(40);
        pulse();
        wait_inv(1'b1, 20, cnt);
        wait_inv(1'b0, 120, cnt);
        chk("invalid span", 32'(cnt >= 45 && cnt <= 90), 32'h0000_0001);
        cyc(40);
        chk("ramp step", 32'(14'(last_word - prev_word)), 32'h0000_0001);
        chk("ramp resync", 32'((last_word - 14'h2000) < 14'h0010), 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0002 | (32'(PAT_RAMP) << CTRL_GPAT_LSB));
        pulse();
        cnt = 0;
        repeat (30) begin
            @(posedge pclk);
            cnt += int'(sample_invalid !== 1'b0);
        end
        chk("masked trigger", 32'(cnt), 32'h0000_0000);
        cyc(60);
        apb(1'b1, OFS_CTRL, 32'h0000_0003 | (32'(PAT_RAMP) << CTRL_GPAT_LSB));
        apb(1'b1, OFS_CTRL, 32'h0000_0002 | (32'(PAT_RAMP) << CTRL_GPAT_LSB));
        cyc(16);
        chk("soft resync", 32'((last_word - 14'h2000) < 14'h0004), 32'h0000_0001);
        final_report();
    end
endmodule
`default_nettype wire
